// ===== include/eeprom_pkg.sv
// constants, types and carriers of the serial eeprom command engine
package eeprom_pkg;

  localparam int CLK_MHZ              = 25;
  localparam int CLK_PERIOD_NS        = 40;
  localparam int SELECT_LOW_TIME_NS   = 250;
  localparam int SELECT_LOW_CYCLES    = (SELECT_LOW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_TIME_US         = 6000;
  localparam int ERASE_ALL_TIME_US    = 6000;
  localparam int WRITE_ALL_TIME_US    = 15000;
  localparam int PROG_CYCLES          = PROG_TIME_US * CLK_MHZ;
  localparam int ERASE_ALL_CYCLES     = ERASE_ALL_TIME_US * CLK_MHZ;
  localparam int WRITE_ALL_CYCLES     = WRITE_ALL_TIME_US * CLK_MHZ;
  localparam int ADDR_W               = 9;
  localparam int WORD_W               = 8;
  localparam int FIFO_DEPTH           = 32;
  localparam int TIMER_W              = 24;

  localparam logic [1:0] OPC_EXT      = 2'h0;
  localparam logic [1:0] OPC_WRITE    = 2'h1;
  localparam logic [1:0] OPC_READ     = 2'h2;
  localparam logic [1:0] OPC_ERASE    = 2'h3;
  localparam logic [1:0] EXT_DISABLE  = 2'h0;
  localparam logic [1:0] EXT_WR_ALL   = 2'h1;
  localparam logic [1:0] EXT_ER_ALL   = 2'h2;
  localparam logic [1:0] EXT_ENABLE   = 2'h3;

  typedef enum logic [4:0] {
    ST_WAIT = 5'h01,
    ST_CMD  = 5'h02,
    ST_DATA = 5'h04,
    ST_READ = 5'h08,
    ST_DONE = 5'h10
  } frame_e;

  typedef enum logic [4:0] {
    PG_NONE      = 5'h01,
    PG_ERASE     = 5'h02,
    PG_WRITE     = 5'h04,
    PG_ERASE_ALL = 5'h08,
    PG_WRITE_ALL = 5'h10
  } prog_e;

  typedef struct packed {
    logic device_select;
    logic serial_clock;
    logic serial_in;
  } link_pins_s;

endpackage : eeprom_pkg

// ===== hw/pin_sync.sv
// two-flop synchroniser for pins arriving from outside the clock domain
module pin_sync #(
  parameter int WIDTH = 3
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // pins
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule : pin_sync

// ===== hw/word_fifo.sv
// read-ahead fifo between the array and the serial shifter
module word_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             flush,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0]      wr_ptr;
  logic [PW:0]      rd_ptr;

  assign out_valid = wr_ptr != rd_ptr;
  assign in_ready  = (wr_ptr[PW-1:0] != rd_ptr[PW-1:0]) || (wr_ptr[PW] == rd_ptr[PW]);
  assign out_data  = mem[rd_ptr[PW-1:0]];

  always_ff @(posedge clk) begin
    if (in_valid && in_ready && !flush) begin
      mem[wr_ptr[PW-1:0]] <= in_data;
    end
  end

  // flush wins so a stale word never reaches a new read frame
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (in_valid && in_ready) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (out_valid && out_ready) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

endmodule : word_fifo

// ===== hw/serial_eeprom_command_engine.sv
// instruction engine of a three-wire serial eeprom with its array
module serial_eeprom_command_engine #(
  parameter int ADDR_W           = eeprom_pkg::ADDR_W,
  parameter int WORD_W           = eeprom_pkg::WORD_W,
  parameter int FIFO_DEPTH       = eeprom_pkg::FIFO_DEPTH,
  parameter int PROG_CYCLES      = eeprom_pkg::PROG_CYCLES,
  parameter int ERASE_ALL_CYCLES = eeprom_pkg::ERASE_ALL_CYCLES,
  parameter int WRITE_ALL_CYCLES = eeprom_pkg::WRITE_ALL_CYCLES
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // serial link pins
  input  wire logic device_select,
  input  wire logic serial_clock,
  input  wire logic serial_in,
  output logic      serial_out,
  output logic      serial_out_oe
);

  localparam int DEPTH    = 2 ** ADDR_W;
  localparam int CMD_BITS = 2 + ADDR_W;
  localparam int TW       = eeprom_pkg::TIMER_W;

  typedef struct packed {
    eeprom_pkg::link_pins_s pins_d;
    eeprom_pkg::frame_e     frame;
    logic [7:0]             bit_cnt;
    logic [ADDR_W:0]        cmd_sh;
    logic [WORD_W-1:0]      data_sh;
    logic [WORD_W-1:0]      out_sh;
    logic [7:0]             out_left;
    logic                   dout;
    logic                   dout_oe;
    logic                   enabled;
    eeprom_pkg::prog_e      pending;
    logic [ADDR_W-1:0]      pend_addr;
    logic [WORD_W-1:0]      pend_data;
    logic                   busy;
    eeprom_pkg::prog_e      prog_op;
    logic [ADDR_W-1:0]      prog_addr;
    logic [WORD_W-1:0]      prog_data;
    logic [ADDR_W:0]        sweep;
    logic [TW-1:0]          timer;
    logic [7:0]             low_cnt;
    logic                   status_armed;
    logic                   status_show;
    logic [ADDR_W-1:0]      fetch_addr;
    logic                   fetch_on;
  } state_s;

  state_s                 s;
  state_s                 next_s;
  eeprom_pkg::link_pins_s pins;
  logic [2:0]             pins_raw;
  logic                   sclk_rise;
  logic                   cs_fall;
  logic                   cs_rise;
  logic                   is_all;
  logic                   sweep_done;
  logic                   mem_we;
  logic [ADDR_W-1:0]      mem_waddr;
  logic [WORD_W-1:0]      mem_wdata;
  logic [WORD_W-1:0]      mem [DEPTH];
  logic                   fifo_flush;
  logic                   fifo_in_ready;
  logic                   fifo_out_valid;
  logic                   fifo_pop;
  logic [WORD_W-1:0]      fifo_out_data;
  logic [ADDR_W+1:0]      cmd_word;
  logic [1:0]             ext;

  pin_sync #(.WIDTH(3)) u_sync (
    .clk   (clk),
    .reset (reset),
    .din   ({device_select, serial_clock, serial_in}),
    .dout  (pins_raw)
  );

  assign pins      = eeprom_pkg::link_pins_s'(pins_raw);
  assign sclk_rise = pins.serial_clock && !s.pins_d.serial_clock;
  assign cs_fall   = !pins.device_select && s.pins_d.device_select;
  assign cs_rise   = pins.device_select && !s.pins_d.device_select;
  assign cmd_word  = {s.cmd_sh, pins.serial_in};
  assign ext       = cmd_word[ADDR_W-1:ADDR_W-2];

  // whole-array cycles walk one word per clock, inside the timed window
  assign is_all     = s.prog_op inside {eeprom_pkg::PG_ERASE_ALL, eeprom_pkg::PG_WRITE_ALL};
  assign sweep_done = is_all ? (s.sweep == (ADDR_W+1)'(DEPTH)) : (s.sweep != '0);
  assign mem_we     = s.busy && !sweep_done;
  assign mem_waddr  = is_all ? s.sweep[ADDR_W-1:0] : s.prog_addr;
  assign mem_wdata  = (s.prog_op inside {eeprom_pkg::PG_ERASE, eeprom_pkg::PG_ERASE_ALL})
                      ? '1 : s.prog_data;

  // array holds no reset: it stands for nonvolatile storage
  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem[mem_waddr] <= mem_wdata;
    end
  end

  word_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .reset     (reset),
    .flush     (fifo_flush),
    .in_valid  (s.fetch_on),
    .in_ready  (fifo_in_ready),
    .in_data   (mem[s.fetch_addr]),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data)
  );

  always_comb begin
    next_s     = s;
    fifo_flush = 1'b0;
    fifo_pop   = 1'b0;
    next_s.pins_d = pins;

    // self-timed engine runs on clk alone
    if (s.busy) begin
      if (!sweep_done) begin
        next_s.sweep = s.sweep + 1'b1;
      end
      if (s.timer != '0) begin
        next_s.timer = s.timer - 1'b1;
      end else if (sweep_done) begin
        next_s.busy = 1'b0;
      end
    end

    // read-ahead stalls on a full fifo and wraps at the array end
    if (s.fetch_on && fifo_in_ready) begin
      next_s.fetch_addr = s.fetch_addr + 1'b1;
    end

    if (!pins.device_select) begin
      next_s.frame       = eeprom_pkg::ST_WAIT;
      next_s.dout_oe     = 1'b0;
      next_s.status_show = 1'b0;
      next_s.fetch_on    = 1'b0;
      next_s.pending     = eeprom_pkg::PG_NONE;
      fifo_flush         = 1'b1;
      if (s.low_cnt != 8'hff) begin
        next_s.low_cnt = s.low_cnt + 1'b1;
      end
      // deselect commits a fully clocked programming frame
      if (cs_fall && s.frame == eeprom_pkg::ST_DONE && s.enabled && !s.busy
          && s.pending != eeprom_pkg::PG_NONE) begin
        next_s.busy         = 1'b1;
        next_s.prog_op      = s.pending;
        next_s.prog_addr    = s.pend_addr;
        next_s.prog_data    = s.pend_data;
        next_s.sweep        = '0;
        next_s.status_armed = 1'b1;
        unique case (s.pending)
          eeprom_pkg::PG_ERASE_ALL: next_s.timer = TW'(ERASE_ALL_CYCLES);
          eeprom_pkg::PG_WRITE_ALL: next_s.timer = TW'(WRITE_ALL_CYCLES);
          default:                  next_s.timer = TW'(PROG_CYCLES);
        endcase
      end
    end else begin
      next_s.low_cnt = '0;
      if (cs_rise && s.status_armed
          && s.low_cnt >= 8'(eeprom_pkg::SELECT_LOW_CYCLES)) begin
        next_s.status_show = 1'b1;
      end
      if (sclk_rise) begin
        unique case (s.frame)
          eeprom_pkg::ST_WAIT: begin
            // no new frame while programming: status keeps the pin
            if (pins.serial_in && !s.busy) begin
              next_s.frame        = eeprom_pkg::ST_CMD;
              next_s.bit_cnt      = '0;
              next_s.status_armed = 1'b0;
              next_s.status_show  = 1'b0;
              next_s.dout_oe      = 1'b0;
            end
          end
          eeprom_pkg::ST_CMD: begin
            next_s.cmd_sh    = cmd_word[ADDR_W:0];
            next_s.bit_cnt   = s.bit_cnt + 1'b1;
            next_s.pend_addr = cmd_word[ADDR_W-1:0];
            if (s.bit_cnt == 8'(CMD_BITS - 1)) begin
              next_s.frame   = eeprom_pkg::ST_DONE;
              next_s.bit_cnt = '0;
              unique case (cmd_word[ADDR_W+1:ADDR_W])
                eeprom_pkg::OPC_READ: begin
                  next_s.frame      = eeprom_pkg::ST_READ;
                  next_s.dout       = 1'b0;
                  next_s.dout_oe    = 1'b1;
                  next_s.out_left   = '0;
                  next_s.fetch_addr = cmd_word[ADDR_W-1:0];
                  next_s.fetch_on   = 1'b1;
                  fifo_flush        = 1'b1;
                end
                eeprom_pkg::OPC_WRITE: begin
                  next_s.frame   = eeprom_pkg::ST_DATA;
                  next_s.pending = eeprom_pkg::PG_WRITE;
                end
                eeprom_pkg::OPC_ERASE: next_s.pending = eeprom_pkg::PG_ERASE;
                eeprom_pkg::OPC_EXT: begin
                  unique case (ext)
                    eeprom_pkg::EXT_ENABLE:  next_s.enabled = 1'b1;
                    eeprom_pkg::EXT_DISABLE: next_s.enabled = 1'b0;
                    eeprom_pkg::EXT_ER_ALL:  next_s.pending = eeprom_pkg::PG_ERASE_ALL;
                    eeprom_pkg::EXT_WR_ALL: begin
                      next_s.frame   = eeprom_pkg::ST_DATA;
                      next_s.pending = eeprom_pkg::PG_WRITE_ALL;
                    end
                  endcase
                end
              endcase
            end
          end
          eeprom_pkg::ST_DATA: begin
            next_s.data_sh   = {s.data_sh[WORD_W-2:0], pins.serial_in};
            next_s.pend_data = {s.data_sh[WORD_W-2:0], pins.serial_in};
            next_s.bit_cnt   = s.bit_cnt + 1'b1;
            if (s.bit_cnt == 8'(WORD_W - 1)) begin
              next_s.frame = eeprom_pkg::ST_DONE;
            end
          end
          eeprom_pkg::ST_READ: begin
            if (s.out_left == '0) begin
              fifo_pop        = 1'b1;
              next_s.dout     = fifo_out_data[WORD_W-1];
              next_s.out_sh   = {fifo_out_data[WORD_W-2:0], 1'b0};
              next_s.out_left = 8'(WORD_W - 1);
            end else begin
              next_s.dout     = s.out_sh[WORD_W-1];
              next_s.out_sh   = {s.out_sh[WORD_W-2:0], 1'b0};
              next_s.out_left = s.out_left - 1'b1;
            end
          end
          eeprom_pkg::ST_DONE: begin
            next_s.frame = eeprom_pkg::ST_DONE;
          end
        endcase
      end
    end

    // status owns the pin until deselect or the next start bit
    if (next_s.status_show) begin
      next_s.dout    = !next_s.busy;
      next_s.dout_oe = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s         <= '0;
      s.frame   <= eeprom_pkg::ST_WAIT;
      s.pending <= eeprom_pkg::PG_NONE;
      s.prog_op <= eeprom_pkg::PG_NONE;
      s.enabled <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  assign serial_out    = s.dout;
  assign serial_out_oe = s.dout_oe;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_start_bit;
    (s.frame == eeprom_pkg::ST_WAIT) ##1 (s.frame == eeprom_pkg::ST_CMD)
      |-> $past(pins.serial_in && sclk_rise && pins.device_select);
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("frame began without start bit");

  property p_release;
    !pins.device_select |=> !serial_out_oe;
  endproperty
  a_release: assert property (p_release) else $error("output driven while deselected");

  property p_disabled;
    (!s.enabled && !s.busy) |=> !s.busy;
  endproperty
  a_disabled: assert property (p_disabled) else $error("programming while disabled");

  property p_dummy_zero;
    (s.frame == eeprom_pkg::ST_CMD && next_s.frame == eeprom_pkg::ST_READ)
      |=> serial_out_oe && !serial_out;
  endproperty
  a_dummy_zero: assert property (p_dummy_zero) else $error("no dummy zero before read");

  property p_start_at_fall;
    $rose(s.busy) |-> $past(cs_fall && s.frame == eeprom_pkg::ST_DONE);
  endproperty
  a_start_at_fall: assert property (p_start_at_fall) else $error("cycle began off deselect");

  property p_timer_runs;
    (s.busy && s.timer != '0) |=> s.timer == $past(s.timer) - 1'b1;
  endproperty
  a_timer_runs: assert property (p_timer_runs) else $error("cycle timer stalled");

  property p_finish;
    (s.busy && s.timer == '0 && sweep_done) |=> !s.busy;
  endproperty
  a_finish: assert property (p_finish) else $error("cycle did not end");

  property p_status;
    s.status_show |-> serial_out_oe && (serial_out == !s.busy);
  endproperty
  a_status: assert property (p_status) else $error("status level wrong");

  property p_enable_hold;
    $fell(s.enabled) |-> $past(s.frame == eeprom_pkg::ST_CMD && sclk_rise);
  endproperty
  a_enable_hold: assert property (p_enable_hold) else $error("enable lost without command");

  property p_done_hold;
    (s.frame == eeprom_pkg::ST_DONE && pins.device_select) |=> s.frame == eeprom_pkg::ST_DONE;
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("frame left done while selected");

  // the pop does not look at valid, so the read-ahead must lead at every word boundary
  property p_word_ready;
    (s.frame == eeprom_pkg::ST_READ && sclk_rise && s.out_left == '0 && pins.device_select)
      |-> fifo_out_valid;
  endproperty
  a_word_ready: assert property (p_word_ready) else $error("read word not fetched in time");

  c_read:   cover property (s.frame == eeprom_pkg::ST_READ && fifo_pop);
  c_prog:   cover property ($rose(s.busy));
  c_status: cover property (s.status_show && !s.busy);
  c_all:    cover property (s.busy && s.prog_op == eeprom_pkg::PG_WRITE_ALL);

endmodule : serial_eeprom_command_engine

// ===== bench/eeprom_host.sv
// host controller model driving the three-wire serial link
module eeprom_host (
  // clock
  input  wire logic clk,
  // link pins
  output logic      device_select,
  output logic      serial_clock,
  output logic      serial_in,
  input  wire logic serial_out,
  input  wire logic serial_out_oe
);
  timeunit 1ns;
  timeprecision 100ps;

  // no pull-up on the line: a released output shows the inverse of its last level
  logic data_line;
  assign data_line = serial_out_oe ? serial_out : !serial_out;

  // serial clock stands low outside frames
  initial begin
    device_select = 1'b0;
    serial_clock  = 1'b0;
    serial_in     = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : tick

  // 8 clk per bit; data set up 4 clk before the rise, past the two sync flops
  task automatic send_bit(input logic b);
    serial_in = b;
    tick(4);
    serial_clock = 1'b1;
    tick(4);
    serial_clock = 1'b0;
  endtask : send_bit

  // start bit, opcode, address, then n data bits, all msb first
  task automatic frame(input logic [1:0] op, input logic [8:0] addr,
                       input logic [7:0] data, input int n);
    device_select = 1'b1;
    send_bit(1'b1);
    for (int i = 1; i >= 0; i--) send_bit(op[i]);
    for (int i = 8; i >= 0; i--) send_bit(addr[i]);
    for (int i = 7; i > 7 - n; i--) send_bit(data[i]);
    // input is don't care now; flip it so a stale level is never trusted
    serial_in = ~serial_in;
    tick(1);
  endtask : frame

  task automatic select();
    device_select = 1'b1;
    tick(4);
  endtask : select

  // low for 10 clk, beyond the 7 clk the engine measures
  task automatic deselect();
    device_select = 1'b0;
    serial_in     = 1'b0;
    tick(10);
  endtask : deselect

  // sample each bit 8 clk after the rise that launched it
  task automatic read_word(output logic [7:0] w);
    for (int i = 7; i >= 0; i--) begin
      serial_clock = 1'b1;
      tick(4);
      serial_clock = 1'b0;
      tick(4);
      w[i] = data_line;
    end
  endtask : read_word
endmodule : eeprom_host

// ===== bench/test_serial_eeprom_command_engine.sv
// self-checking bench of the serial eeprom command engine
module test_serial_eeprom_command_engine;
  timeunit 1ns;
  timeprecision 100ps;

  // shortened self-timed cycles keep the run brief
  localparam int PROG_N = 1000;
  localparam int ERASE_ALL_CMD_N = 1100;
  localparam int WRITE_ALL_CMD_N = 1200;

  logic clk;
  logic reset;
  logic device_select;
  logic serial_clock;
  logic serial_in;
  logic serial_out;
  logic serial_out_oe;
  int   fail_count = 0;
  int   n_tests    = 0;
  int   cycles     = 0;

  serial_eeprom_command_engine #(
    .PROG_CYCLES      (PROG_N),
    .ERASE_ALL_CYCLES (ERASE_ALL_CMD_N),
    .WRITE_ALL_CYCLES (WRITE_ALL_CMD_N)
  ) dut (
    .clk           (clk),
    .reset         (reset),
    .device_select (device_select),
    .serial_clock  (serial_clock),
    .serial_in     (serial_in),
    .serial_out    (serial_out),
    .serial_out_oe (serial_out_oe)
  );

  eeprom_host host (
    .clk           (clk),
    .device_select (device_select),
    .serial_clock  (serial_clock),
    .serial_in     (serial_in),
    .serial_out    (serial_out),
    .serial_out_oe (serial_out_oe)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude

  // ceiling well above the roughly 10000 clk the scenarios need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      conclude();
    end
  end

  task automatic check_bit(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit

  task automatic check_word(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word

  // reselect after the low time: busy first, then ready within the limit
  task automatic poll_status(input int limit);
    int n;
    n = 0;
    host.select();
    check_bit("status enable", 1'b1, serial_out_oe);
    check_bit("busy level", 1'b0, host.data_line);
    while (host.data_line !== 1'b1 && n < limit) begin
      host.tick(1);
      n++;
    end
    check_bit("ready level", 1'b1, host.data_line);
    host.deselect();
  endtask : poll_status

  // a refused instruction leaves no status to show
  task automatic no_status();
    host.select();
    check_bit("no status", 1'b0, serial_out_oe);
    host.deselect();
  endtask : no_status

  // leading idle clocks with input low must not start a frame
  task automatic read_at(input logic [8:0] addr, input logic [7:0] exp0,
                         input logic [7:0] exp1);
    logic [7:0] w;
    host.select();
    repeat (3) host.send_bit(1'b0);
    host.frame(eeprom_pkg::OPC_READ, addr, 8'h00, 0);
    host.tick(4);
    check_bit("read enable", 1'b1, serial_out_oe);
    check_bit("dummy bit", 1'b0, serial_out);
    host.read_word(w);
    check_word("read word", exp0, w);
    host.read_word(w);
    check_word("next word", exp1, w);
    host.deselect();
    check_bit("released", 1'b0, serial_out_oe);
  endtask : read_at

  task automatic s_power_up();
    host.frame(eeprom_pkg::OPC_WRITE, 9'h003, 8'h5a, 8);
    host.deselect();
    no_status();
    host.frame(eeprom_pkg::OPC_EXT, 9'h180, 8'h00, 0);
    host.tick(4);
    check_bit("enable silent", 1'b0, serial_out_oe);
    host.deselect();
    host.frame(eeprom_pkg::OPC_EXT, 9'h100, 8'h00, 0);
    host.deselect();
    poll_status(ERASE_ALL_CMD_N + 100);
    read_at(9'h1ff, 8'hff, 8'hff);
  endtask : s_power_up

  task automatic s_write_erase();
    host.frame(eeprom_pkg::OPC_WRITE, 9'h003, 8'h5a, 8);
    host.deselect();
    poll_status(PROG_N + 100);
    host.frame(eeprom_pkg::OPC_WRITE, 9'h004, 8'hc3, 8);
    repeat (2) host.send_bit(1'b1);
    host.deselect();
    poll_status(PROG_N + 100);
    read_at(9'h003, 8'h5a, 8'hc3);
    host.frame(eeprom_pkg::OPC_ERASE, 9'h003, 8'h00, 0);
    host.deselect();
    poll_status(PROG_N + 100);
    read_at(9'h003, 8'hff, 8'hc3);
    // select held low through the whole cycle: it still completes
    host.frame(eeprom_pkg::OPC_ERASE, 9'h003, 8'h00, 0);
    host.deselect();
    host.tick(PROG_N + 20);
    host.select();
    check_bit("done while low", 1'b1, host.data_line);
    host.deselect();
    host.frame(eeprom_pkg::OPC_WRITE, 9'h004, 8'h00, 7);
    host.deselect();
    no_status();
  endtask : s_write_erase

  task automatic s_disable_all();
    host.frame(eeprom_pkg::OPC_EXT, 9'h000, 8'h00, 0);
    host.deselect();
    host.frame(eeprom_pkg::OPC_WRITE, 9'h004, 8'h00, 8);
    host.deselect();
    no_status();
    host.frame(eeprom_pkg::OPC_EXT, 9'h080, 8'h96, 8);
    host.deselect();
    no_status();
    read_at(9'h004, 8'hc3, 8'hff);
    host.frame(eeprom_pkg::OPC_EXT, 9'h180, 8'h00, 0);
    host.deselect();
    host.frame(eeprom_pkg::OPC_EXT, 9'h080, 8'h96, 8);
    host.deselect();
    poll_status(WRITE_ALL_CMD_N + 100);
    read_at(9'h1ff, 8'h96, 8'h96);
    host.frame(eeprom_pkg::OPC_EXT, 9'h000, 8'h00, 0);
    host.deselect();
  endtask : s_disable_all

  initial begin
    reset = 1'b1;
    repeat (5) @(posedge clk);
    #2;
    reset = 1'b0;
    host.tick(4);
    s_power_up();
    s_write_erase();
    s_disable_all();
    conclude();
  end
endmodule : test_serial_eeprom_command_engine
